/* File: hw/ttsc_debounce.v */
`include "ttsc_defines.vh"

module ttsc_debounce (
    input  wire        clk_i,    // core clock
    input  wire        rstn_i,   // async reset, active low
    input  wire        ce_i,     // clock enable
    input  wire        sample_i, // one new key sample
    input  wire [11:0] key_i,    // raw detected keys
    input  wire [7:0]  count_i,  // debounce count
    output reg  [11:0] state_o   // accepted key state
);

    reg [11:0] cand_r; // candidate key pattern
    reg [7:0]  cnt_r;  // consecutive detections of candidate

    ////////////////////////////////////////////////////////////////////////
    // count repeats, accept once repeats exceed the debounce count
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cand_r  <= 12'h000;
            cnt_r   <= `TTSC_ZERO8;
            state_o <= 12'h000;
        end else if (ce_i && sample_i) begin
            if (key_i != cand_r) begin
                // new pattern, restart the run
                cand_r <= key_i;
                cnt_r  <= 8'h01;
            end else if (cnt_r != 8'hFF) begin
                cnt_r <= cnt_r + 8'h01;
            end
            if (count_i == `TTSC_ZERO8) begin
                state_o <= key_i;
            end else if (key_i == cand_r && cnt_r >= count_i) begin
                state_o <= key_i;
            end
        end
    end

endmodule

/* File: hw/ttsc_top.v */
// Behaviour
// - check level is tenth of threshold times step
// - two samples over check, then wake level
// - accept key after more than debounce repeats
// - release interrupt low pulse after millisecond delay
// - release delay never stored to flash
// - 0xAA saves touch configuration to flash
// - 0x5A saves calibration settings to flash
// - after reset load configuration from flash
// - write-only recalibration bit starts recalibration
// - reset pin is active low
// - output select high single, low multi
// - serial and interrupt pins only pull low
`include "ttsc_defines.vh"

module ttsc_top #(
    parameter integer MS_CYC = `TTSC_MS_NS / `TTSC_CLK_NS // cycles per ms
) (
    input  wire        clk_i,          // core clock, 25 MHz
    input  wire        rstn_i,         // reset pin, active low
    input  wire        ce_i,           // clock enable
    input  wire        scl_i,          // serial clock pin level
    output wire        scl_o,          // serial clock drive value
    output wire        scl_oen_o,      // serial clock enable, low drives
    input  wire        sda_i,          // serial data pin level
    output wire        sda_o,          // serial data drive value
    output wire        sda_oen_o,      // serial data enable, low drives
    output wire        irq_o,          // interrupt drive value
    output wire        irq_oen_o,      // interrupt enable, low drives
    input  wire        port_en_i,      // serial port enable pin
    input  wire        key_sel_i,      // output mode strap pin
    input  wire        sample_i,       // touch engine sample strobe
    input  wire [11:0] key_raw_i,      // raw detected keys
    input  wire        idle_i,         // device is in idle mode
    input  wire [15:0] diff_i,         // touch difference value
    input  wire [15:0] thr_i,          // touch threshold
    input  wire [7:0]  wake_level_i,   // wake level step
    input  wire        flash_valid_i,  // flash holds saved config
    input  wire [15:0] flash_cfg_i,    // saved config word
    input  wire        flash_done_i,   // flash save finished
    input  wire        recalibrate_cmd_done_i,   // recalibration finished
    output wire        flash_req_o,    // flash save request
    output wire        flash_cal_o,    // request is calibration save
    output wire [15:0] flash_data_o,   // config word to save
    output wire        recalibrate_cmd_req_o,    // recalibration request
    output reg         wake_o,         // wake from idle pulse
    output reg         single_o,       // single-key output mode
    output reg  [11:0] key_out_o,      // reported keys
    output reg  [7:0]  wakecl_o,       // wake check level step
    output reg  [7:0]  debnc_o         // debounce count
);

    localparam integer PULSE_CYC = `TTSC_PULSE_NS / `TTSC_CLK_NS;
    localparam integer MS_END    = MS_CYC - 1;    // last cycle of a ms
    localparam integer PLS_END   = PULSE_CYC - 1; // last pulse cycle
    // cut to counter width on purpose
    localparam [15:0]  MS_LAST   = MS_END[15:0];
    localparam [7:0]   PLS_LAST  = PLS_END[7:0];

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers, three stages, accept when last two agree
    reg  [3:0] sy1_r;   // first stage
    reg  [3:0] sy2_r;   // second stage
    reg  [3:0] sy3_r;   // third stage
    reg  [3:0] pin_r;   // filtered pin levels
    reg  [3:0] pin_q_r; // previous filtered levels
    wire [3:0] pin_raw; // raw pin bundle

    assign pin_raw = {key_sel_i, port_en_i, sda_i, scl_i};

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sy1_r   <= `TTSC_PIN_IDLE;
            sy2_r   <= `TTSC_PIN_IDLE;
            sy3_r   <= `TTSC_PIN_IDLE;
            pin_r   <= `TTSC_PIN_IDLE;
            pin_q_r <= `TTSC_PIN_IDLE;
        end else if (ce_i) begin
            sy1_r   <= pin_raw;
            sy2_r   <= sy1_r;
            sy3_r   <= sy2_r;
            pin_r   <= (sy2_r & sy3_r) | (pin_r & (sy2_r ^ sy3_r));
            pin_q_r <= pin_r;
        end
    end

    wire scl_rise = pin_r[`TTSC_PIN_SCL] & ~pin_q_r[`TTSC_PIN_SCL];
    wire scl_fall = ~pin_r[`TTSC_PIN_SCL] & pin_q_r[`TTSC_PIN_SCL];
    wire scl_hi   = pin_r[`TTSC_PIN_SCL] & pin_q_r[`TTSC_PIN_SCL];
    wire sda_fall = ~pin_r[`TTSC_PIN_SDA] & pin_q_r[`TTSC_PIN_SDA];
    wire sda_rise = pin_r[`TTSC_PIN_SDA] & ~pin_q_r[`TTSC_PIN_SDA];
    wire bus_on   = pin_r[`TTSC_PIN_SPE];
    wire spe_fall = ~pin_r[`TTSC_PIN_SPE] & pin_q_r[`TTSC_PIN_SPE];

    ////////////////////////////////////////////////////////////////////////
    // serial bus slave, pointer plus auto-increment data bytes
    reg  [3:0] st_r;    // slave state
    reg  [3:0] bcnt_r;  // bit counter
    reg  [7:0] shr_r;   // receive shift register
    reg  [7:0] tx_r;    // transmit shift register
    reg  [7:0] ptr_r;   // register pointer
    reg        rw_r;    // current transfer is a read
    reg        mack_r;  // master acknowledge, high is nack
    reg        drv_r;   // pulling data line low
    reg  [7:0] rdata;   // read mux
    reg        save_busy_r; // flash save accepted
    reg  [7:0] reldly_r;    // release interrupt delay
    reg  [7:0] save_r;      // flash save command
    reg        recalibrate_cmd_r;     // recalibration command pending
    wire       wr_stb;      // data byte write strobe

    assign wr_stb = ce_i & bus_on & scl_fall & ~(scl_hi) &
                    (st_r == `TTSC_ST_WDAT) & (bcnt_r == `TTSC_BITS_BYTE);

    // read mux, save command reads back as stored, recalibration command reads zero
    always @* begin
        case (ptr_r)
            `TTSC_ADDR_WAKECL: rdata = wakecl_o;
            `TTSC_ADDR_DEBNC:  rdata = debnc_o;
            `TTSC_ADDR_RELDLY: rdata = reldly_r;
            `TTSC_ADDR_SAVE:   rdata = save_r;
            default:           rdata = `TTSC_ZERO8; // write-only, unmapped
        endcase
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r   <= `TTSC_ST_IDLE;
            bcnt_r <= `TTSC_BIT_NONE;
            shr_r  <= `TTSC_ZERO8;
            tx_r   <= `TTSC_ZERO8;
            ptr_r  <= `TTSC_ZERO8;
            rw_r   <= 1'b0;
            mack_r <= 1'b1;
            drv_r  <= 1'b0;
        end else if (ce_i) begin
            if (!bus_on) begin
                // port disabled, stay off the bus
                st_r  <= `TTSC_ST_IDLE;
                drv_r <= 1'b0;
            end else if (scl_hi && sda_fall) begin
                // start or repeated start
                st_r   <= `TTSC_ST_ADDR;
                bcnt_r <= `TTSC_BIT_NONE;
                drv_r  <= 1'b0;
            end else if (scl_hi && sda_rise) begin
                // stop
                st_r  <= `TTSC_ST_IDLE;
                drv_r <= 1'b0;
            end else if (scl_rise) begin
                if (st_r == `TTSC_ST_RACK) begin
                    mack_r <= pin_r[`TTSC_PIN_SDA];
                end else begin
                    shr_r  <= {shr_r[6:0], pin_r[`TTSC_PIN_SDA]};
                    bcnt_r <= bcnt_r + `TTSC_BIT_FIRST;
                end
            end else if (scl_fall) begin
                case (st_r)
                    `TTSC_ST_ADDR: begin
                        if (bcnt_r == `TTSC_BITS_BYTE) begin
                            if (shr_r[7:1] == `TTSC_DEV_ADDR) begin
                                drv_r <= 1'b1;
                                rw_r  <= shr_r[0];
                                st_r  <= `TTSC_ST_AACK;
                            end else begin
                                st_r <= `TTSC_ST_IDLE;
                            end
                        end
                    end
                    `TTSC_ST_AACK: begin
                        if (rw_r) begin
                            // bit count advances on each clock rise except in the read ack slot
                            tx_r   <= rdata;
                            drv_r  <= ~rdata[7];
                            bcnt_r <= `TTSC_BIT_NONE;
                            st_r   <= `TTSC_ST_RDAT;
                        end else begin
                            drv_r  <= 1'b0;
                            bcnt_r <= `TTSC_BIT_NONE;
                            st_r   <= `TTSC_ST_PTR;
                        end
                    end
                    `TTSC_ST_PTR: begin
                        if (bcnt_r == `TTSC_BITS_BYTE) begin
                            ptr_r <= shr_r;
                            drv_r <= 1'b1;
                            st_r  <= `TTSC_ST_PACK;
                        end
                    end
                    `TTSC_ST_PACK, `TTSC_ST_WACK: begin
                        drv_r  <= 1'b0;
                        bcnt_r <= `TTSC_BIT_NONE;
                        st_r   <= `TTSC_ST_WDAT;
                    end
                    `TTSC_ST_WDAT: begin
                        if (bcnt_r == `TTSC_BITS_BYTE) begin
                            ptr_r <= ptr_r + 8'h01;
                            drv_r <= 1'b1;
                            st_r  <= `TTSC_ST_WACK;
                        end
                    end
                    `TTSC_ST_RDAT: begin
                        if (bcnt_r == `TTSC_BITS_BYTE) begin
                            drv_r <= 1'b0;
                            ptr_r <= ptr_r + 8'h01;
                            st_r  <= `TTSC_ST_RACK;
                        end else begin
                            // next bit, count already moved on the rise
                            tx_r   <= {tx_r[6:0], 1'b0};
                            drv_r  <= ~tx_r[6];
                        end
                    end
                    `TTSC_ST_RACK: begin
                        if (!mack_r) begin
                            tx_r   <= rdata;
                            drv_r  <= ~rdata[7];
                            bcnt_r <= `TTSC_BIT_NONE;
                            st_r   <= `TTSC_ST_RDAT;
                        end else begin
                            st_r <= `TTSC_ST_IDLE;
                        end
                    end
                    default: st_r <= `TTSC_ST_IDLE;
                endcase
            end
        end
    end

    // open-drain: only ever pull low, never stretch the clock
    assign sda_o     = 1'b0;
    assign sda_oen_o = ~drv_r;
    assign scl_o     = 1'b0;
    assign scl_oen_o = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // configuration and command registers
    reg boot_r; // first enabled cycle after reset release

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wakecl_o <= `TTSC_RST_WAKECL;
            debnc_o  <= `TTSC_RST_DEBNC;
            reldly_r <= `TTSC_RST_RELDLY;
            save_r   <= `TTSC_RST_SAVE;
            recalibrate_cmd_r  <= `TTSC_RST_RECALIBRATE_CMD;
            boot_r   <= 1'b1;
        end else if (ce_i) begin
            boot_r <= 1'b0;
            // saved configuration replaces defaults once after reset
            if (boot_r && flash_valid_i) begin
                wakecl_o <= flash_cfg_i[`TTSC_CFG_WAKECL];
                debnc_o  <= flash_cfg_i[`TTSC_CFG_DEBNC];
            end
            // completion returns commands to idle, a new write wins
            if (flash_done_i) begin
                save_r <= `TTSC_ZERO8;
            end
            if (recalibrate_cmd_done_i) begin
                recalibrate_cmd_r <= 1'b0;
            end
            if (wr_stb) begin
                case (ptr_r)
                    `TTSC_ADDR_WAKECL: wakecl_o <= shr_r;
                    `TTSC_ADDR_DEBNC:  debnc_o  <= shr_r;
                    `TTSC_ADDR_RELDLY: reldly_r <= shr_r;
                    `TTSC_ADDR_SAVE:   save_r   <= shr_r;
                    `TTSC_ADDR_RECALIBRATE_CMD: begin
                        if (shr_r[`TTSC_RECALIBRATE_CMD_BIT]) begin
                            recalibrate_cmd_r <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            save_busy_r <= 1'b0;
        end else if (ce_i) begin
            save_busy_r <= flash_req_o & ~flash_done_i;
        end
    end

    // only the two command codes request a flash save
    assign flash_req_o  = (save_r == `TTSC_SAVE_CFG) |
                          (save_r == `TTSC_SAVE_CAL);
    assign flash_cal_o  = (save_r == `TTSC_SAVE_CAL);
    // release delay is left out of the saved word
    assign flash_data_o = {debnc_o, wakecl_o};
    assign recalibrate_cmd_req_o  = recalibrate_cmd_r;

    ////////////////////////////////////////////////////////////////////////
    // key debounce and output mode
    wire [11:0] key_acc;   // debounced key state
    reg  [11:0] key_q_r;   // previous debounced state

    ttsc_debounce u_deb (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .ce_i     (ce_i),
        .sample_i (sample_i),
        .key_i    (key_raw_i),
        .count_i  (debnc_o),
        .state_o  (key_acc)
    );

    // single mode reports lowest touched key only
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            key_q_r   <= 12'h000;
            key_out_o <= 12'h000;
            single_o  <= 1'b0;
        end else if (ce_i) begin
            key_q_r  <= key_acc;
            single_o <= pin_r[`TTSC_PIN_KSEL];
            if (pin_r[`TTSC_PIN_KSEL]) begin
                key_out_o <= key_acc & ~(key_acc - 12'h001);
            end else begin
                key_out_o <= key_acc;
            end
        end
    end

    wire release_ev = |(key_q_r & ~key_acc);

    ////////////////////////////////////////////////////////////////////////
    // release interrupt: wait delay in ms, then fixed low pulse
    reg        pend_r;  // delay running
    reg [15:0] ms_cnt_r;// cycles within current ms
    reg [7:0]  ms_left_r; // ms still to wait
    reg [7:0]  pls_r;   // pulse cycles left
    reg        pls_on_r;// pulse active

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_r    <= 1'b0;
            ms_cnt_r  <= 16'h0000;
            ms_left_r <= `TTSC_ZERO8;
            pls_r     <= `TTSC_ZERO8;
            pls_on_r  <= 1'b0;
        end else if (ce_i) begin
            if (pls_on_r) begin
                if (pls_r == `TTSC_ZERO8) begin
                    pls_on_r <= 1'b0;
                end else begin
                    pls_r <= pls_r - 8'h01;
                end
            end
            if (release_ev) begin
                pend_r    <= 1'b1;
                ms_left_r <= reldly_r;
                ms_cnt_r  <= 16'h0000;
            end else if (pend_r) begin
                if (ms_left_r == `TTSC_ZERO8) begin
                    pend_r   <= 1'b0;
                    pls_on_r <= 1'b1;
                    pls_r    <= PLS_LAST;
                end else if (ms_cnt_r == MS_LAST) begin
                    ms_cnt_r  <= 16'h0000;
                    ms_left_r <= ms_left_r - 8'h01;
                end else begin
                    ms_cnt_r <= ms_cnt_r + 16'h0001;
                end
            end
        end
    end

    assign irq_o     = 1'b0;
    assign irq_oen_o = ~pls_on_r;

    ////////////////////////////////////////////////////////////////////////
    // idle wake: two samples over check level, then wake level
    wire [23:0] diff_x10 = {8'h00, diff_i} * `TTSC_PCT_DIV;
    wire [23:0] chk_lvl  = thr_i * wakecl_o;
    wire [23:0] wk_lvl   = thr_i * wake_level_i;
    wire        over_chk = diff_x10 > chk_lvl;
    wire        over_wk  = diff_x10 > wk_lvl;
    reg  [1:0]  hits_r;  // consecutive samples over check level

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hits_r <= 2'b00;
            wake_o <= 1'b0;
        end else if (ce_i) begin
            // port enable low pulse also wakes the device
            wake_o <= spe_fall & idle_i;
            if (!idle_i) begin
                hits_r <= 2'b00;
            end else if (sample_i) begin
                if (!over_chk) begin
                    hits_r <= 2'b00;
                end else if (hits_r != 2'b10) begin
                    hits_r <= hits_r + 2'b01;
                end else if (over_wk) begin
                    wake_o <= 1'b1;
                    hits_r <= 2'b00;
                end
            end
        end
    end

endmodule

/* File: inc/ttsc_defines.vh */
`ifndef TTSC_DEFINES_VH
`define TTSC_DEFINES_VH

// register byte addresses on the serial bus
`define TTSC_ADDR_WAKECL   8'h25
`define TTSC_ADDR_DEBNC    8'h26
`define TTSC_ADDR_RELDLY   8'h27
`define TTSC_ADDR_SAVE     8'h2A
`define TTSC_ADDR_RECALIBRATE_CMD    8'hFE

// reset values
`define TTSC_RST_WAKECL    8'h05
`define TTSC_RST_DEBNC     8'h02
`define TTSC_RST_RELDLY    8'h14
`define TTSC_RST_SAVE      8'h00
`define TTSC_RST_RECALIBRATE_CMD     1'b0
`define TTSC_ZERO8         8'h00

// command codes for the flash save register
`define TTSC_SAVE_CFG      8'hAA
`define TTSC_SAVE_CAL      8'h5A

// recalibration command bit position
`define TTSC_RECALIBRATE_CMD_BIT     0

// packing of saved configuration word
`define TTSC_CFG_WAKECL    7:0
`define TTSC_CFG_DEBNC     15:8

// step unit of the wake levels is a tenth of the threshold
`define TTSC_PCT_DIV       24'h00000A

// serial bus slave address, value arbitrary
`define TTSC_DEV_ADDR      7'h2C

// timing
`define TTSC_CLK_NS        40
`define TTSC_MS_NS         1000000
`define TTSC_PULSE_NS      2000

// pin synchroniser lanes and their idle levels
`define TTSC_PIN_SCL       0
`define TTSC_PIN_SDA       1
`define TTSC_PIN_SPE       2
`define TTSC_PIN_KSEL      3
`define TTSC_PIN_IDLE      4'h7

// serial bus slave states and bit counter values
`define TTSC_ST_IDLE       4'h0
`define TTSC_ST_ADDR       4'h1
`define TTSC_ST_AACK       4'h2
`define TTSC_ST_PTR        4'h3
`define TTSC_ST_PACK       4'h4
`define TTSC_ST_WDAT       4'h5
`define TTSC_ST_WACK       4'h6
`define TTSC_ST_RDAT       4'h7
`define TTSC_ST_RACK       4'h8
`define TTSC_BITS_BYTE     4'h8
`define TTSC_BIT_FIRST     4'h1
`define TTSC_BIT_NONE      4'h0

`endif

/* File: sim/ttsc_host.sv */
`include "ttsc_defines.vh"
module ttsc_host (
    input  wire logic clk_i, // core clock
    input  wire logic sda_i, // resolved data line
    output logic      scl_o, // clock, high releases
    output logic      sda_o  // data, high releases
);
    timeunit 1ns;
    timeprecision 1ns;
    initial scl_o = 1'b1;
    initial sda_o = 1'b1;
    // quarter bit, phases over ten clocks
    task automatic st(input logic c, d);
        repeat (10) @(posedge clk_i);
        scl_o <= c;
        sda_o <= d;
    endtask
    // clock low, data a, clock high, data b: bit, start or stop
    task automatic cd(input logic a, b, output logic q);
        st(1'b0, sda_o);
        st(1'b0, a);
        st(1'b1, a);
        q = sda_i;
        st(1'b1, b);
    endtask
    // byte msb first, then released ack slot
    task automatic by(input logic [7:0] b, output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--) cd(b[i], b[i], q[i]);
        cd(1'b1, 1'b1, a);
    endtask
    // start, address, pointer
    task automatic hd(input logic [7:0] a);
        logic [7:0] q;
        cd(1'b1, 1'b0, q[0]);
        by({`TTSC_DEV_ADDR, 1'b0}, q);
        by(a, q);
    endtask
    task automatic wr(input logic [7:0] a, d);
        logic [7:0] q;
        hd(a);
        by(d, q);
        cd(1'b0, 1'b1, q[0]);
    endtask
    // repeated start, one byte, nack
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic s;
        hd(a);
        cd(1'b1, 1'b0, d[0]);
        by({`TTSC_DEV_ADDR, 1'b1}, d);
        by(8'hFF, d);
        cd(1'b0, 1'b1, s);
    endtask
endmodule

/* File: sim/ttsc_monitor.sv */
module ttsc_monitor (
    input wire        clk_i,        // core clock
    input wire        rstn_i,       // reset, active low
    input wire        scl_o,        // clock drive value
    input wire        scl_oen_o,    // clock enable, low drives
    input wire        sda_o,        // data drive value
    input wire        irq_o,        // irq drive value
    input wire        irq_oen_o,    // irq enable, low drives
    input wire        flash_done_i, // save finished
    input wire        recalibrate_cmd_done_i, // recalibrate_cmd finished
    input wire        flash_req_o,  // save request
    input wire        flash_cal_o,  // calibration save
    input wire [15:0] flash_data_o, // word to save
    input wire        recalibrate_cmd_req_o,  // recalibrate_cmd request
    input wire        wake_o,       // wake pulse
    input wire [7:0]  wakecl_o,     // check level
    input wire [7:0]  debnc_o       // debounce count
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    AST_SCL_REL: assert property (scl_oen_o)
        else $error("clock pin driven");
    AST_OD_LOW: assert property (!(scl_o | sda_o | irq_o))
        else $error("pin driven high");
    AST_IRQ_PULSE: assert property ($fell(irq_oen_o) |->
        ##49 !irq_oen_o ##1 irq_oen_o) else $error("irq pulse width");
    AST_CAL_REQ: assert property (flash_cal_o |-> flash_req_o)
        else $error("cal save without request");
    AST_REQ_HOLD: assert property (flash_req_o & !flash_done_i |=>
        flash_req_o) else $error("save request dropped");
    AST_REQ_CLR: assert property (flash_done_i |=> !flash_req_o)
        else $error("save request stuck");
    AST_RECALIBRATE_CMD_CLR: assert property (recalibrate_cmd_done_i |=> !recalibrate_cmd_req_o)
        else $error("recalibrate_cmd request stuck");
    AST_DATA: assert property (flash_data_o == {debnc_o, wakecl_o})
        else $error("save word wrong");
    AST_WAKE_ONE: assert property (wake_o |=> !wake_o)
        else $error("wake pulse too long");
endmodule

/* File: sim/ttsc_top_tb.sv */
`include "ttsc_defines.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
    $display("mismatch %0t %h %h", $time, a, b); end end
module ttsc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = '0, rstn_i = '0, sample_i = '0, idle_i = '0;
    logic        key_sel_i = '0, flash_valid_i = '0;
    logic        ce_i = 1'b1, port_en_i = 1'b1;
    logic        flash_done_i = '0, recalibrate_cmd_done_i = '0;
    logic [11:0] key_raw_i = '0;
    logic [15:0] diff_i = '0, thr_i = 16'h0064, flash_cfg_i = 16'h0307;
    logic [7:0]  wake_level_i = 8'h0A, rd, rv;
    logic [7:0]  al [6] = '{8'h25, 8'h26, 8'h27, 8'h2A, 8'hFE, 8'h30};
    wire         scl_o, scl_oen_o, sda_o, sda_oen_o, irq_o, irq_oen_o;
    wire         flash_req_o, flash_cal_o, recalibrate_cmd_req_o, wake_o, single_o;
    wire         h_scl, h_sda;
    wire [15:0]  flash_data_o;
    wire [11:0]  key_out_o;
    wire [7:0]   wakecl_o, debnc_o;
    wire         sda = h_sda & sda_oen_o; // pull-up wire
    int          errors = 0, num_checks = 0, wk = 0, n, m [256];
    ttsc_top #(.MS_CYC(10)) ttsc_top_i (.*,
        .scl_i(h_scl & scl_oen_o), .sda_i(sda));
    ttsc_host ttsc_host_i (.clk_i, .sda_i(sda), .scl_o(h_scl), .sda_o(h_sda));
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) if (wake_o === 1'b1) wk++;
    task automatic wr(input logic [7:0] a, d);
        ttsc_host_i.wr(a, d);
        if (a != 8'hFE) m[a] = d;
    endtask
    task automatic rc(input logic [7:0] a);
        ttsc_host_i.rd(a, rd);
        `CHK(rd, m[a][7:0])
    endtask
    // c key samples, three idle clocks each
    task automatic smp(input logic [11:0] k, input int c);
        repeat (c) begin
            key_raw_i <= k;
            sample_i <= 1'b1;
            @(posedge clk_i);
            sample_i <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask
    // done strobe, flash when f
    task automatic dn(input logic f);
        {flash_done_i, recalibrate_cmd_done_i} <= {f, !f};
        @(posedge clk_i);
        {flash_done_i, recalibrate_cmd_done_i} <= 2'b00;
        @(posedge clk_i);
    endtask
    task automatic end_sim;
        if (errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h530dd77e));
        m[8'h25] = 5;
        m[8'h26] = 2;
        m[8'h27] = 8'h14;
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        foreach (al[i]) rc(al[i]);
        wr(`TTSC_ADDR_RELDLY, 8'h02);
        smp(12'h001, 2);
        `CHK(key_out_o, 12'h000)
        smp(12'h001, 1);
        `CHK(key_out_o, 12'h001)
        smp(12'h000, 3);
        for (n = 0; n < 300 && irq_oen_o; n++) @(posedge clk_i);
        `CHK(n inside {[14:26]}, 1'b1)
        for (n = 0; n < 300 && !irq_oen_o; n++) @(posedge clk_i);
        `CHK(n, 50)
        for (int i = 0; i < 2; i++) begin
            wr(`TTSC_ADDR_SAVE, i ? `TTSC_SAVE_CAL : `TTSC_SAVE_CFG);
            `CHK({flash_req_o, flash_cal_o}, {1'b1, i[0]})
            `CHK(flash_data_o, 16'h0205)
            dn(1'b1);
            m[8'h2A] = 0;
            rc(`TTSC_ADDR_SAVE);
        end
        wr(`TTSC_ADDR_RECALIBRATE_CMD, 8'h00);
        `CHK(recalibrate_cmd_req_o, 1'b0)
        wr(`TTSC_ADDR_RECALIBRATE_CMD, 8'h01);
        `CHK(recalibrate_cmd_req_o, 1'b1)
        dn(1'b0);
        `CHK(recalibrate_cmd_req_o, 1'b0)
        idle_i <= 1'b1;
        diff_i <= 16'h0078;
        smp(12'h000, 2);
        `CHK(wk, 0)
        smp(12'h000, 1);
        `CHK(wk, 1)
        port_en_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        port_en_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        `CHK(wk, 2)
        idle_i <= 1'b0;
        key_sel_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        `CHK(single_o, 1'b1)
        ce_i <= 1'b0;
        key_sel_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        `CHK(single_o, 1'b1)
        {ce_i, key_sel_i} <= 2'b11;
        smp(12'h006, 3);
        `CHK(key_out_o, 12'h002)
        rv = 8'($urandom);
        wr(`TTSC_ADDR_WAKECL, rv);
        `CHK(wakecl_o, rv)
        flash_valid_i <= 1'b1;
        rstn_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        `CHK({sda_oen_o, irq_oen_o, wake_o}, 3'b110)
        rstn_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        `CHK({debnc_o, wakecl_o}, 16'h0307)
        m[8'h27] = 8'h14;
        rc(`TTSC_ADDR_RELDLY);
        end_sim;
    end
endmodule
bind ttsc_top ttsc_monitor ttsc_monitor_i (.*);
